// ### rtl/t16_pkg.sv
// Package: register map, field layout, mode codes and prescaler figures of the 16-bit timer
package t16_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_COUNT = 3'h1;
  localparam logic [2:0] ADR_CMPA = 3'h2;
  localparam logic [2:0] ADR_CMPB = 3'h3;
  localparam logic [2:0] ADR_CAPT = 3'h4;
  localparam logic [2:0] ADR_FLAGS = 3'h5;
  localparam logic [2:0] ADR_FORCE = 3'h6;
  localparam logic [2:0] ADR_WAVE = 3'h7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned MODE_W = 4;
  localparam int unsigned CS_W = 3;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACTA_LSB = 4;
  localparam int unsigned CTRL_ACTB_LSB = 6;
  localparam int unsigned CTRL_CS_LSB = 8;
  localparam int unsigned CTRL_DIRA = 11;
  localparam int unsigned CTRL_DIRB = 12;
  localparam int unsigned CTRL_W = 13;

  // Flag register bits, write one to clear
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAPT = 3;
  localparam int unsigned FLG_W = 4;

  // ----------------------------------------------------------------
  // Waveform modes and output actions
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FPWM8 = 4'h5;
  localparam logic [3:0] MODE_FPWM9 = 4'h6;
  localparam logic [3:0] MODE_FPWM10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
  localparam logic [3:0] MODE_FPWM_CAPT = 4'hE;
  localparam logic [3:0] MODE_FPWM_A = 4'hF;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Counter extremes and fixed TOP values
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP8 = 16'h00FF;
  localparam logic [15:0] TOP9 = 16'h01FF;
  localparam logic [15:0] TOP10 = 16'h03FF;

  // ----------------------------------------------------------------
  // Prescaler: clock select codes and last count of each divider
  // ----------------------------------------------------------------
  localparam int unsigned PRE_W = 10;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_LAST8 = 10'h007;
  localparam logic [9:0] PRE_LAST64 = 10'h03F;
  localparam logic [9:0] PRE_LAST256 = 10'h0FF;
  localparam logic [9:0] PRE_LAST1024 = 10'h3FF;

endpackage

// ### rtl/t16_prescaler.sv
// Prescaler: one-cycle timer clock enable from the I/O clock
`timescale 1ns/1ps

module t16_prescaler
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [t16_pkg::CS_W-1:0] clk_sel_i,
  output logic tick_o
);
  import t16_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic tick;
  } t16_pre_s;

  t16_pre_s st_ff;
  t16_pre_s nxt_st;

  // Last count before the enable for each select code
  function automatic logic [PRE_W-1:0] last_of(input logic [CS_W-1:0] sel);
    case (sel)
      CS_DIV8: last_of = PRE_LAST8;
      CS_DIV64: last_of = PRE_LAST64;
      CS_DIV256: last_of = PRE_LAST256;
      CS_DIV1024: last_of = PRE_LAST1024;
      default: last_of = '0;
    endcase
  endfunction

  // Divider; a stopped clock also parks the count so a restart is aligned
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (clk_sel_i == CS_STOP || clk_sel_i > CS_DIV1024)
      nxt_st.cnt = '0;
    else if (st_ff.cnt >= last_of(clk_sel_i))
    begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end
    else
      nxt_st.cnt = st_ff.cnt + 1'b1;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign tick_o = st_ff.tick;

endmodule

// ### rtl/t16_wave_unit.sv
// Waveform state of one compare channel
`timescale 1ns/1ps

module t16_wave_unit
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] action_i,
  input wire logic pwm_i,
  input wire logic toggle_ok_i,
  input wire logic match_i,
  input wire logic bottom_i,
  input wire logic force_i,
  output logic wave_o
);
  import t16_pkg::*;

  typedef struct packed {
    logic wave;
  } t16_wave_s;

  t16_wave_s st_ff;
  t16_wave_s nxt_st;

  // Action on match; in PWM the wrap to BOTTOM wins so compare == TOP is a flat level
  always_comb
  begin
    nxt_st = st_ff;
    if (!pwm_i)
    begin
      if (match_i || force_i)
      begin
        case (action_i)
          ACT_TOGGLE: nxt_st.wave = ~st_ff.wave;
          ACT_CLEAR: nxt_st.wave = 1'b0;
          ACT_SET: nxt_st.wave = 1'b1;
          default: nxt_st.wave = st_ff.wave;
        endcase
      end
    end
    else
    begin
      case (action_i)
        ACT_TOGGLE: if (toggle_ok_i && match_i) nxt_st.wave = ~st_ff.wave;
        ACT_CLEAR: if (bottom_i) nxt_st.wave = 1'b1; else if (match_i) nxt_st.wave = 1'b0;
        ACT_SET: if (bottom_i) nxt_st.wave = 1'b0; else if (match_i) nxt_st.wave = 1'b1;
        default: nxt_st.wave = st_ff.wave;
      endcase
    end
  end

  // State register, cleared by reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign wave_o = st_ff.wave;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wave_none_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (action_i == ACT_NONE) |=> $stable(wave_o))
    else $error("wave state moved with no action selected");

endmodule

// ### rtl/t16_timer.sv
// Top of the 16-bit timer/counter: registers, counter, compare and flag logic
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module t16_timer
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [t16_pkg::ADDR_W-1:0] addr_i,
  input wire logic [t16_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic port_a_i,
  input wire logic port_b_i,
  output logic [t16_pkg::DATA_W-1:0] rd_data_o,
  output logic pin_a_o,
  output logic pin_a_oe_o,
  output logic pin_b_o,
  output logic pin_b_oe_o
);
  import t16_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] count;
    logic [1:0][DATA_W-1:0] cmp;
    logic [1:0][DATA_W-1:0] cbuf;
    logic [DATA_W-1:0] capt;
    logic [FLG_W-1:0] flags;
    logic block;
    logic [DATA_W-1:0] rd_data;
    logic [1:0] pin;
    logic [1:0] pin_oe;
  } t16_state_s;

  t16_state_s st_ff;
  t16_state_s nxt_st;

  logic tick;
  logic [MODE_W-1:0] mode;
  logic [1:0][1:0] action;
  logic [1:0] dir;
  logic [1:0] port_in;
  logic pwm;
  logic clear_on_match_mode;
  logic var_top;
  logic capt_top;
  logic [DATA_W-1:0] top;
  logic top_hit;
  logic pwm_top;
  logic wrap;
  logic wr_count;
  logic [1:0] cmp_hit;
  logic [1:0] frc;
  logic [1:0] wave;
  logic [FLG_W-1:0] flg_set;

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  function automatic logic is_pwm(input logic [MODE_W-1:0] m);
    is_pwm = (m == MODE_FPWM8) || (m == MODE_FPWM9) || (m == MODE_FPWM10) ||
             (m == MODE_FPWM_CAPT) || (m == MODE_FPWM_A);
  endfunction

  // TOP for each mode; unsupported codes count like normal mode
  function automatic logic [DATA_W-1:0] top_of(input logic [MODE_W-1:0] m,
                                               input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] c);
    case (m)
      MODE_CTC_A, MODE_FPWM_A: top_of = a;
      MODE_CTC_CAPT, MODE_FPWM_CAPT: top_of = c;
      MODE_FPWM8: top_of = TOP8;
      MODE_FPWM9: top_of = TOP9;
      MODE_FPWM10: top_of = TOP10;
      default: top_of = COUNT_MAX;
    endcase
  endfunction

  // Write mask for compare values; fixed TOP values are all-ones masks
  function automatic logic [DATA_W-1:0] fix_mask(input logic [MODE_W-1:0] m);
    case (m)
      MODE_FPWM8: fix_mask = TOP8;
      MODE_FPWM9: fix_mask = TOP9;
      MODE_FPWM10: fix_mask = TOP10;
      default: fix_mask = COUNT_MAX;
    endcase
  endfunction

  // Control fields
  assign mode = st_ff.ctrl[CTRL_MODE_LSB +: MODE_W];
  assign action[0] = st_ff.ctrl[CTRL_ACTA_LSB +: 2];
  assign action[1] = st_ff.ctrl[CTRL_ACTB_LSB +: 2];
  assign dir = {st_ff.ctrl[CTRL_DIRB], st_ff.ctrl[CTRL_DIRA]};
  assign port_in = {port_b_i, port_a_i};
  assign pwm = is_pwm(mode);
  assign clear_on_match_mode = (mode == MODE_CTC_A) || (mode == MODE_CTC_CAPT);
  assign capt_top = (mode == MODE_CTC_CAPT) || (mode == MODE_FPWM_CAPT);
  assign var_top = clear_on_match_mode || capt_top || (mode == MODE_FPWM_A);
  assign top = top_of(mode, st_ff.cmp[0], st_ff.capt);

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  t16_prescaler u_pre
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_sel_i(st_ff.ctrl[CTRL_CS_LSB +: CS_W]),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Match and event detection
  // ----------------------------------------------------------------
  // Equality only: a TOP written below the count is simply passed by
  assign wr_count = wr_i && (addr_i == ADR_COUNT);
  assign top_hit = tick && (st_ff.count == top) && !(st_ff.block && var_top);
  assign pwm_top = top_hit && pwm;
  assign wrap = tick && (st_ff.count == COUNT_MAX);
  assign cmp_hit[0] = tick && !st_ff.block && (st_ff.count == st_ff.cmp[0]);
  assign cmp_hit[1] = tick && !st_ff.block && (st_ff.count == st_ff.cmp[1]);
  assign frc = (wr_i && addr_i == ADR_FORCE && !pwm) ? wr_data_i[1:0] : 2'b00;

  // Flag sources
  assign flg_set[FLG_OVF] = pwm ? pwm_top : wrap;
  assign flg_set[FLG_CMPA] = cmp_hit[0];
  assign flg_set[FLG_CMPB] = cmp_hit[1];
  assign flg_set[FLG_CAPT] = top_hit && capt_top;

  // ----------------------------------------------------------------
  // Waveform units
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : g_wave
    t16_wave_unit u_wave
    (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .action_i(action[g]),
      .pwm_i(pwm),
      .toggle_ok_i((g == 0) && (mode == MODE_FPWM_A)),
      .match_i(cmp_hit[g]),
      .bottom_i(pwm_top),
      .force_i(frc[g]),
      .wave_o(wave[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;

    // Control and capture written directly; mode never touches the action fields
    if (wr_i && addr_i == ADR_CTRL)
      nxt_st.ctrl = wr_data_i[CTRL_W-1:0];
    if (wr_i && addr_i == ADR_CAPT)
      nxt_st.capt = wr_data_i;

    // Counter: a software write wins over the enable in the same cycle
    if (wr_count)
      nxt_st.count = wr_data_i;
    else if (tick)
    begin
      if (top_hit && (clear_on_match_mode || pwm))
        nxt_st.count = BOTTOM;
      else
        nxt_st.count = DATA_W'(st_ff.count + 1'b1);
    end

    // Match blocking lasts until one timer tick has been swallowed
    if (wr_count)
      nxt_st.block = 1'b1;
    else if (tick)
      nxt_st.block = 1'b0;

    // Compare channels: buffered in PWM, direct otherwise
    for (int i = 0; i < 2; i++)
    begin
      if (pwm_top)
        nxt_st.cmp[i] = st_ff.cbuf[i];
      if (wr_i && addr_i == ((i == 0) ? ADR_CMPA : ADR_CMPB))
        nxt_st.cbuf[i] = wr_data_i & fix_mask(mode);
      if (!pwm)
        nxt_st.cmp[i] = nxt_st.cbuf[i];
    end

    // Flags: a set in the clearing cycle survives
    nxt_st.flags = st_ff.flags;
    if (wr_i && addr_i == ADR_FLAGS)
      nxt_st.flags = st_ff.flags & ~wr_data_i[FLG_W-1:0];
    nxt_st.flags = nxt_st.flags | flg_set;

    // Read data stands only in the cycle after the strobe
    nxt_st.rd_data = '0;
    if (rd_i)
    begin
      case (addr_i)
        ADR_CTRL: nxt_st.rd_data = {{(DATA_W - CTRL_W){1'b0}}, st_ff.ctrl};
        ADR_COUNT: nxt_st.rd_data = st_ff.count;
        ADR_CMPA: nxt_st.rd_data = st_ff.cbuf[0];
        ADR_CMPB: nxt_st.rd_data = st_ff.cbuf[1];
        ADR_CAPT: nxt_st.rd_data = st_ff.capt;
        ADR_FLAGS: nxt_st.rd_data = {{(DATA_W - FLG_W){1'b0}}, st_ff.flags};
        ADR_WAVE: nxt_st.rd_data = {{(DATA_W - 2){1'b0}}, wave};
        default: nxt_st.rd_data = '0;
      endcase
    end

    // Pin override by the wave state; direction alone decides driving
    for (int i = 0; i < 2; i++)
    begin
      nxt_st.pin[i] = (action[i] != ACT_NONE) ? wave[i] : port_in[i];
      nxt_st.pin_oe[i] = dir[i];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Full clear leaves normal mode with the clock stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign rd_data_o = st_ff.rd_data;
  assign pin_a_o = st_ff.pin[0];
  assign pin_b_o = st_ff.pin[1];
  assign pin_a_oe_o = st_ff.pin_oe[0];
  assign pin_b_oe_o = st_ff.pin_oe[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_clear_a: assert property (disable iff (1'b0)
    rst_i |=> (st_ff.count == BOTTOM) && (st_ff.flags == '0) && (wave == 2'b00) && (mode == MODE_NORMAL))
    else $error("reset left state behind");

  normal_count_a: assert property (
    (mode == MODE_NORMAL) && tick && !wr_count |=> st_ff.count == DATA_W'($past(st_ff.count) + 1'b1))
    else $error("normal mode did not count up by one");

  normal_ovf_a: assert property (
    (mode == MODE_NORMAL) && tick && !wr_count && (st_ff.count == COUNT_MAX)
    |=> (st_ff.count == BOTTOM) && st_ff.flags[FLG_OVF])
    else $error("overflow not set as count became zero");

  ctc_clear_a: assert property (
    (mode == MODE_CTC_A) && tick && !wr_count && !st_ff.block && (st_ff.count == st_ff.cmp[0])
    |=> (st_ff.count == BOTTOM) && st_ff.flags[FLG_CMPA])
    else $error("clear-on-match missed compare A");

  ctc_toggle_a: assert property (
    (mode == MODE_CTC_A) && (action[0] == ACT_TOGGLE) && cmp_hit[0] |=> wave[0] != $past(wave[0]))
    else $error("toggle action did not flip the wave");

  pwm_top_a: assert property (
    pwm && tick && !wr_count && (st_ff.count == top) && !var_top
    |=> (st_ff.count == BOTTOM) && st_ff.flags[FLG_OVF] && (st_ff.cmp[1] == $past(st_ff.cbuf[1])))
    else $error("fast PWM TOP handling wrong");

  pwm_level_a: assert property (
    pwm_top && (action[0] == ACT_CLEAR) |=> wave[0])
    else $error("non-inverted wave not set at BOTTOM");

  // Helper: a count write stays pending until one timer tick has gone by, however long the clock stops
  logic blk_seen_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      blk_seen_ff <= 1'b0;
    else if (wr_count)
      blk_seen_ff <= 1'b1;
    else if (tick)
      blk_seen_ff <= 1'b0;
  end

  match_block_a: assert property (
    blk_seen_ff && tick |-> !cmp_hit[0] && !cmp_hit[1])
    else $error("compare matched right after a count write");

  // Software may clear the flag without a tick, but only a tick may raise it
  hold_count_a: assert property (
    !tick && !wr_count |=> $stable(st_ff.count) && !$rose(st_ff.flags[FLG_OVF]))
    else $error("counter moved without a timer tick");

  capt_top_flag_a: assert property (
    pwm && capt_top && top_hit && !wr_count
    |=> (st_ff.count == BOTTOM) && st_ff.flags[FLG_CAPT] && st_ff.flags[FLG_OVF])
    else $error("capture TOP did not set its flags");

  fixed_mask_a: assert property (
    wr_i && (addr_i == ADR_CMPA) && (mode == MODE_FPWM8) |=> st_ff.cbuf[0][15:8] == 8'h00)
    else $error("compare bits above fixed TOP kept");

  pin_dir_a: assert property (
    1'b1 |=> (pin_a_oe_o == $past(dir[0])) && (pin_b_oe_o == $past(dir[1])))
    else $error("pin drive not following direction bit");

  cov_ctc_wrap_c: cover property (clear_on_match_mode && top_hit);
  cov_pwm_top_c: cover property (pwm_top && (mode == MODE_FPWM_A));
  cov_force_c: cover property (frc != 2'b00);
  cov_normal_ovf_c: cover property ((mode == MODE_NORMAL) && wrap);

endmodule

// ### tb/t16_pin_model.sv
// Port pad model: resolves the timer pin driver against an external pull-up
`timescale 1ns/1ps

module t16_pin_model
(
  input wire logic pin_i,
  input wire logic oe_i,
  output logic pad_o
);
  // Released pad floats high, so a stale driver value never shows
  assign pad_o = oe_i ? pin_i : 1'b1;
endmodule

// ### tb/t16_timer_tb_top.sv
// Testbench of the 16-bit timer: register accesses, counting, flags and pin waveforms
`timescale 1ns/1ps

module t16_timer_tb_top;
  import t16_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic port_a_i = 1'b0;
  logic port_b_i = 1'b0;
  logic [15:0] rd_data_o;
  logic pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o, pad_a, pad_b;
  logic [15:0] d;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi;
  int ed;
  logic [15:0] cmp_t[4] = '{16'h0002, 16'h0000, 16'h0007, 16'h0002};
  logic [1:0] act_t[4] = '{ACT_CLEAR, ACT_CLEAR, ACT_CLEAR, ACT_SET};
  logic [15:0] hi_t[4] = '{16'h000C, 16'h0004, 16'h0020, 16'h0014};
  logic [2:0] cs_t[5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
  int div_t[5] = '{1, 8, 64, 256, 1024};

  always #25 clk_i = ~clk_i;

  t16_timer dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .port_a_i(port_a_i), .port_b_i(port_b_i), .rd_data_o(rd_data_o), .pin_a_o(pin_a_o),
    .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));
  t16_pin_model pad_a_m (.pin_i(pin_a_o), .oe_i(pin_a_oe_o), .pad_o(pad_a));
  t16_pin_model pad_b_m (.pin_i(pin_b_o), .oe_i(pin_b_oe_o), .pad_o(pad_b));

  // ----------------------------------------------------------------
  // Bus, compare and measurement tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_reg(input string n, input logic [2:0] a, input logic [15:0] e);
    rd(a);
    chk(n, e, d);
  endtask

  function automatic logic [15:0] ctl(input logic [3:0] m, input logic [1:0] act, input logic [2:0] cs,
    input logic dir);
    return {3'h0, 1'b0, dir, cs, 2'h0, act, m};
  endfunction

  // Stopped timer, known count, TOP registers and clean flags
  task automatic setup(input logic [15:0] cnt, input logic [15:0] capt, input logic [15:0] cmpa);
    wr(ADR_CTRL, 16'h0000);
    wr(ADR_CAPT, capt);
    wr(ADR_CMPA, cmpa);
    wr(ADR_COUNT, cnt);
    wr(ADR_FLAGS, 16'h000F);
  endtask

  // Undivided clock, then settling time before anything is measured
  task automatic run(input logic [3:0] m, input logic [1:0] act, input logic dir);
    wr(ADR_CTRL, ctl(m, act, CS_DIV1, dir));
    repeat (12) @(posedge clk_i);
  endtask

  // High cycles and level changes of pad A over n cycles
  task automatic meas(input int n);
    logic p;
    hi = 0;
    ed = 0;
    @(posedge clk_i);
    #1;
    p = pad_a;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (pad_a === 1'b1) hi++;
      if (pad_a !== p) ed++;
      p = pad_a;
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well above the longest prescaler run
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_reg("ctrl", ADR_CTRL, 16'h0000);
    chk_reg("flags", ADR_FLAGS, 16'h0000);
    chk_reg("wave", ADR_WAVE, 16'h0000);
    setup(16'hFFF0, 16'h0000, 16'h0000);
    chk_reg("count", ADR_COUNT, 16'hFFF0);
    // Normal mode runs through the wrap and sets overflow
    run(MODE_NORMAL, ACT_NONE, 1'b0);
    repeat (20) @(posedge clk_i);
    wr(ADR_CTRL, 16'h0000);
    rd(ADR_COUNT);
    chk("wrap", 16'h0000, d & 16'hFF00);
    chk_reg("ovf", ADR_FLAGS, 16'h0007);
    wr(ADR_FLAGS, 16'h000F);
    chk_reg("clr", ADR_FLAGS, 16'h0000);
    // Each divider gives about ten ticks in ten periods
    for (int i = 0; i < 5; i++)
    begin
      wr(ADR_COUNT, 16'h0000);
      wr(ADR_CTRL, ctl(MODE_NORMAL, ACT_NONE, cs_t[i], 1'b0));
      repeat (10 * div_t[i]) @(posedge clk_i);
      wr(ADR_CTRL, 16'h0000);
      rd(ADR_COUNT);
      chk("div", 16'h0001, {15'h0, d >= 16'h0009 && d <= 16'h000C});
    end
    // A count write blocks matches only on the very next timer tick
    for (int i = 0; i < 2; i++)
    begin
      setup(16'h0005 - 16'(i), 16'h0000, 16'h0005);
      wr(ADR_CTRL, ctl(MODE_NORMAL, ACT_NONE, CS_DIV1, 1'b0));
      wr(ADR_CTRL, 16'h0000);
      rd(ADR_FLAGS);
      chk("block", 16'(i), (d >> 1) & 16'h0001);
    end
    // Clear-on-match toggle: period of three ticks
    setup(16'h0000, 16'h0000, 16'h0002);
    run(MODE_CTC_A, ACT_TOGGLE, 1'b1);
    meas(24);
    chk("ctc_ed", 16'h0008, 16'(ed));
    chk("ctc_hi", 16'h000C, 16'(hi));
    chk_reg("ctc_flg", ADR_FLAGS, 16'h0006);
    run(MODE_CTC_A, ACT_TOGGLE, 1'b0);
    meas(24);
    chk("dir_off", 16'h0000, 16'(ed));
    chk("oe", 16'h0000, {15'h0, pin_a_oe_o});
    @(posedge clk_i);
    port_a_i <= 1'b1;
    run(MODE_CTC_A, ACT_NONE, 1'b1);
    meas(24);
    chk("port", 16'h0018, 16'(hi));
    // Capture as TOP written below count: wrap first
    // Fourteen ticks: wrap after six, compare A and B at zero match too
    setup(16'hFFFA, 16'h0005, 16'h0000);
    run(MODE_CTC_CAPT, ACT_NONE, 1'b0);
    wr(ADR_CTRL, 16'h0000);
    chk_reg("miss", ADR_FLAGS, 16'h000F);
    rd(ADR_COUNT);
    chk("miss_cnt", 16'h0001, {15'h0, d <= 16'h0005});
    // Fixed 8-bit TOP: clear after 0x00FF, overflow at TOP, count 6 after fourteen ticks
    setup(16'h00F8, 16'h0000, 16'h0000);
    run(MODE_FPWM8, ACT_NONE, 1'b0);
    wr(ADR_CTRL, 16'h0000);
    chk_reg("fix_flg", ADR_FLAGS, 16'h0007);
    rd(ADR_COUNT);
    chk("fix_cnt", 16'h0006, d);
    // Fast PWM on capture TOP: duty by action and compare
    for (int i = 0; i < 4; i++)
    begin
      setup(16'h0000, 16'h0007, cmp_t[i]);
      run(MODE_FPWM_CAPT, act_t[i], 1'b1);
      meas(32);
      chk("duty", hi_t[i], 16'(hi));
    end
    chk_reg("pwm_flg", ADR_FLAGS, 16'h000F);
    run(MODE_FPWM_CAPT, ACT_TOGGLE, 1'b1);
    meas(32);
    chk("no_tgl", 16'h0000, 16'(ed));
    setup(16'h0000, 16'h0000, 16'h0003);
    run(MODE_FPWM_A, ACT_TOGGLE, 1'b1);
    meas(32);
    chk("tgl15", 16'h0008, 16'(ed));
    // Fixed TOP masks compare bits above its width
    wr(ADR_CTRL, ctl(MODE_FPWM8, ACT_NONE, CS_STOP, 1'b0));
    wr(ADR_CMPA, 16'h1234);
    chk_reg("mask8", ADR_CMPA, 16'h1234 & TOP8);
    wr(ADR_CTRL, ctl(MODE_FPWM10, ACT_NONE, CS_STOP, 1'b0));
    wr(ADR_CMPB, 16'hFFFF);
    chk_reg("mask10", ADR_CMPB, TOP10);
    // Channel B: direction B on, set action B, clock stopped; its wave is still zero
    wr(ADR_CTRL, 16'h10C0);
    rd(ADR_WAVE);
    chk("pad_b", 16'h0002, {14'h0, pin_b_oe_o, pad_b});
    wr(ADR_FORCE, 16'h0002);
    rd(ADR_WAVE);
    chk("frc_b", 16'h0002, d & 16'h0002);
    chk("pad_b1", 16'h0003, {14'h0, pin_b_oe_o, pad_b});
    test_done();
  end
endmodule
